// *** verilog/dbarb_pkg.sv ***
// Constants and types shared by the bus arbiter and pin mux
package dbarb_pkg;
  // Arbiter states
  typedef enum logic [2:0] {
    DBARB_OWN,
    DBARB_DRAIN,
    DBARB_FLOAT,
    DBARB_GRANTED,
    DBARB_RECLAIM
  } dbarb_state_t;

  // Cycle of a transfer in which the strobe asserts (second cycle, index 1)
  localparam logic [1:0] DBARB_STROBE_CYCLE = 2'h1;
  // Reset values of outputs
  localparam logic       DBARB_GRANT_RST    = 1'h0;
  localparam logic       DBARB_DRIVE_RST    = 1'h1;
  // Strobe select encodings: bit0 reads, bit1 writes
  localparam int         DBARB_SEL_RD_BIT   = 0;
  localparam int         DBARB_SEL_WR_BIT   = 1;
endpackage

// *** verilog/dbarb_pin_mux.sv ***
// Branch-condition / io strobe pin multiplexer
`timescale 1ns/10ps
module dbarb_pin_mux
  import dbarb_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       branch_input_mode_i,
  input  wire logic [1:0] strobe_sel_i,
  input  wire logic       xfer_active_i,
  input  wire logic       xfer_write_i,
  input  wire logic       pin_in_i,
  output logic            pin_out_o,
  output logic            pin_oe_o,
  output logic            cond3_o
);
  logic [1:0] cycle;
  logic [1:0] next_cycle;
  logic       next_pin_out;
  logic       next_pin_oe;
  logic       next_cond3;
  logic       sel_hit;

  // Count transfer cycles; saturate so long transfers do not wrap
  always_comb begin
    sel_hit = xfer_write_i ? strobe_sel_i[DBARB_SEL_WR_BIT]
                           : strobe_sel_i[DBARB_SEL_RD_BIT];
    next_cycle = cycle;
    if (!xfer_active_i) begin
      next_cycle = 2'h0;
    end else if (cycle != 2'h3) begin
      next_cycle = cycle + 2'h1;
    end
    next_pin_oe  = !branch_input_mode_i;                        // RULE7
    next_pin_out = !branch_input_mode_i && xfer_active_i && sel_hit
                   && (cycle >= DBARB_STROBE_CYCLE);            // RULE9
    next_cond3   = branch_input_mode_i ? pin_in_i : 1'h0;       // RULE8
  end

  // Register pin drive and condition flag
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cycle     <= 2'h0;
      pin_out_o <= 1'h0;
      pin_oe_o  <= 1'h0;
      cond3_o   <= 1'h0;
    end else begin
      cycle     <= next_cycle;
      pin_out_o <= next_pin_out;
      pin_oe_o  <= next_pin_oe;
      cond3_o   <= next_cond3;
    end
  end
endmodule

// *** verilog/dbarb_top.sv ***
// Shared bus arbiter for an external dma master, with strobe pin mux
// Function
// (RULE1) On external request the processor floats its bus outputs.
// (RULE2) Request negation returns the bus; processor resumes driving.
// (RULE3) Grant output acknowledges the detected request.
// (RULE4) Grant rises only after outputs are actually floating.
// (RULE5) A second arbitration protocol is selectable by control setting.
// (RULE6) Second protocol: drop grant early, wait request low, then retake.
// (RULE7) Bus control setting chooses pin role: condition input or strobe.
// (RULE8) Condition mode routes the pin to coprocessor condition 3.
// (RULE9) Strobe mode drives on reads/writes, asserting in transfer cycle two.
// (RULE10) Finish any transfer in progress before floating and granting.
// (RULE11) External master drives only while granted; releases before dropping request.
`timescale 1ns/10ps
module dbarb_top
  import dbarb_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       ext_master_request_i,
  input  wire logic       reclaim_protocol_i,
  input  wire logic       reclaim_want_i,
  input  wire logic       xfer_active_i,
  input  wire logic       xfer_write_i,
  input  wire logic       branch_input_mode_i,
  input  wire logic [1:0] strobe_sel_i,
  input  wire logic       branch_cond_pin3_i,
  output logic            ext_master_grant_o,
  output logic            bus_drive_o,
  output logic            xfer_hold_o,
  output logic            branch_cond_pin3_o,
  output logic            branch_cond_pin3_oe_o,
  output logic            cond3_o
);
  // Ownership walk, one line per clock edge, idle core:
  //   edge 0  request seen high while owning, no transfer running
  //   edge 1  drive drops, hold rises; pins of the bus float from here
  //   edge 2  grant rises; the far master may now drive the bus
  //   edge N  request seen low; next values return to owning
  //   edge N+1 grant low, drive high, hold low
  // Ownership walk with a transfer running at edge 0:
  //   edge 1  drain entered; drive stays high, hold blocks new transfers
  //   edge k  transfer seen idle; next values move to float
  //   edge k+1 float entered, drive drops; edge k+2 grant rises
  // Reclaim walk, second protocol selected and core wanting the bus:
  //   edge 0  granted, protocol on, want high
  //   edge 1  grant drops while the bus stays floated
  //   edge N  request seen low; the far master has let go
  //   edge N+1 drive high again
  // Hazards kept in mind:
  //   - Grant never rises in the same edge as drive drops, so there is
  //     always one full cycle in which neither side drives the bus.
  //   - A request dropped before grant is simply refused; the arbiter
  //     goes back to owning without ever raising grant.
  //   - In reclaim the bus stays floated until request is seen low;
  //     retaking it earlier could clash with a master still finishing.
  //   - Reclaim want is ignored unless the protocol input is set, so the
  //     basic handshake behaves the same whatever want shows.
  // Limitation: the arbiter cannot force the far master off the bus; in
  // reclaim it only signals its wish and waits as long as it takes.
  // Trade-off: outputs are registered from the next state, which costs
  // nothing in latency but keeps every pin glitch free.

  dbarb_state_t state;
  dbarb_state_t next_state;
  logic         next_grant;
  logic         next_drive;
  logic         next_hold;

  // Arbiter next-state logic
  always_comb begin
    next_state = state;
    case (state)
      DBARB_OWN: begin
        if (ext_master_request_i) begin
          // Never cut a transfer short; wait for it to end
          next_state = xfer_active_i ? DBARB_DRAIN : DBARB_FLOAT; // RULE10
        end
      end
      DBARB_DRAIN: begin
        if (!ext_master_request_i) begin
          next_state = DBARB_OWN;
        end else if (!xfer_active_i) begin
          next_state = DBARB_FLOAT;                               // RULE10
        end
      end
      DBARB_FLOAT: begin
        // Outputs floated last cycle; grant is safe now
        next_state = ext_master_request_i ? DBARB_GRANTED : DBARB_OWN; // RULE4
      end
      DBARB_GRANTED: begin
        if (!ext_master_request_i) begin
          next_state = DBARB_OWN;                                 // RULE2
        end else if (reclaim_protocol_i && reclaim_want_i) begin
          next_state = DBARB_RECLAIM;                             // RULE5
        end
      end
      DBARB_RECLAIM: begin
        // Grant is low but the bus stays floated until request drops
        if (!ext_master_request_i) begin
          next_state = DBARB_OWN;                                 // RULE6
        end
      end
      default: begin
        next_state = DBARB_OWN;
      end
    endcase

    // Outputs follow the state being entered, so pins move with it
    next_grant = 1'h0;
    next_drive = 1'h1;
    next_hold  = 1'h0;
    case (next_state)
      DBARB_OWN: begin
        // Core owns the bus and may start transfers
        next_grant = 1'h0;
        next_drive = 1'h1;                                        // RULE2
        next_hold  = 1'h0;
      end
      DBARB_DRAIN: begin
        // Keep driving for the running transfer, block a new one
        next_grant = 1'h0;
        next_drive = 1'h1;                                        // RULE10
        next_hold  = 1'h1;
      end
      DBARB_FLOAT: begin
        // Bus floated, grant held back one cycle for turnaround
        next_grant = 1'h0;
        next_drive = 1'h0;                                        // RULE1
        next_hold  = 1'h1;
      end
      DBARB_GRANTED: begin
        // Far master may drive; core stays off the bus
        next_grant = 1'h1;                                        // RULE3
        next_drive = 1'h0;
        next_hold  = 1'h1;
      end
      DBARB_RECLAIM: begin
        // Grant dropped early as a hint; bus still floated
        next_grant = 1'h0;
        next_drive = 1'h0;                                        // RULE6
        next_hold  = 1'h1;
      end
      default: begin
        // Unused codes behave as owning
        next_grant = 1'h0;
        next_drive = 1'h1;
        next_hold  = 1'h0;
      end
    endcase
  end

  // Arbiter registers; outputs straight from flops
  // Reset leaves the core driving, so the bus is never left floating
  // with nobody owning it while reset is applied
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state              <= DBARB_OWN;
      ext_master_grant_o <= DBARB_GRANT_RST;
      bus_drive_o        <= DBARB_DRIVE_RST;
      xfer_hold_o        <= 1'h0;
    end else begin
      state              <= next_state;
      ext_master_grant_o <= next_grant;
      bus_drive_o        <= next_drive;
      xfer_hold_o        <= next_hold;
    end
  end

  // Strobe / condition pin handling
  // Transfer activity is gated by drive: while the bus is floated the
  // far master's cycles must not fire the core's strobe
  dbarb_pin_mux u_pin_mux (
    .clock_i             (clock_i),
    .rst_b_i             (rst_b_i),
    .branch_input_mode_i (branch_input_mode_i),
    .strobe_sel_i        (strobe_sel_i),
    .xfer_active_i       (xfer_active_i && bus_drive_o),
    .xfer_write_i        (xfer_write_i),
    .pin_in_i            (branch_cond_pin3_i),
    .pin_out_o           (branch_cond_pin3_o),
    .pin_oe_o            (branch_cond_pin3_oe_o),
    .cond3_o             (cond3_o)
  );
endmodule

// *** bench/dbarb_sva.sv ***
// Port checks for the arbiter and strobe pin
`timescale 1ns/10ps
module dbarb_sva (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ext_master_request_i,
  input wire logic reclaim_protocol_i,
  input wire logic reclaim_want_i,
  input wire logic xfer_active_i,
  input wire logic branch_input_mode_i,
  input wire logic branch_cond_pin3_i,
  input wire logic ext_master_grant_o,
  input wire logic bus_drive_o,
  input wire logic branch_cond_pin3_oe_o,
  input wire logic cond3_o
);
  // Short aliases keep the properties readable
  wire r = ext_master_request_i;
  wire g = ext_master_grant_o;
  wire d = bus_drive_o;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  AST_GNT_FLOAT: assert property (g |-> !d) else $error("grant while driving");
  AST_GNT_TIME: assert property ($fell(d) && r |-> ##[0:1] g) else $error("no grant");
  AST_RELEASE: assert property (!r && !d |=> d) else $error("bus not retaken");
  AST_XFER: assert property (xfer_active_i && d |=> d) else $error("float in transfer");
  AST_RECLAIM: assert property (g && r && reclaim_protocol_i && reclaim_want_i |=> !g && !d)
    else $error("reclaim wrong");
  AST_KEEP: assert property (g && r && !(reclaim_protocol_i && reclaim_want_i) |=> g)
    else $error("grant lost");
  AST_COND3: assert property (cond3_o == ($past(branch_input_mode_i) && $past(branch_cond_pin3_i)))
    else $error("cond3 wrong");
  AST_PIN_OE: assert property (branch_cond_pin3_oe_o == !$past(branch_input_mode_i))
    else $error("pin role wrong");
  COV_GRANT: cover property (g);
  COV_RECLAIM: cover property (g ##1 !g && !d);
  COV_COND3: cover property (cond3_o);
endmodule
bind dbarb_top dbarb_sva u_sva (.*);

// *** bench/dbarb_ext_master.sv ***
// External dma master model on the shared bus
`timescale 1ns/10ps
module dbarb_ext_master (
  input  wire logic clock_i,
  input  wire logic want_i,
  input  wire logic gnt_i,
  output logic      req_o = 1'h0,
  output logic      drv_o = 1'h0
);
  logic yield = 1'h0;
  logic gnt_q = 1'h0;
  // Falling edge updates; request outlives drive by one cycle
  always @(negedge clock_i) begin
    drv_o <= want_i & gnt_i & ~yield;
    req_o <= (want_i & ~yield) | drv_o;
    yield <= (yield | (req_o & gnt_q & ~gnt_i)) & want_i;
    gnt_q <= gnt_i;
  end
endmodule

// *** bench/dma_bus_arbiter_branch_port_tb.sv ***
// Testbench for the dma arbiter and strobe pin
`timescale 1ns/10ps
module dma_bus_arbiter_branch_port_tb;
  logic       clock_i = 1'h0, rst_b_i = 1'h0, want = 1'h0, p = 1'h0, w = 1'h0, x = 1'h0;
  logic       wr = 1'h0, m = 1'h1, pin = 1'h0, req, g, d, hold, so, oe, c3;
  logic [1:0] sel = 2'h0;
  int         bad_count = 0, check_count = 0, cycles = 0;
  // Pin level resolved from the design enable
  wire pw = oe ? so : pin;
  dbarb_top u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ext_master_request_i(req),
    .reclaim_protocol_i(p), .reclaim_want_i(w), .xfer_active_i(x), .xfer_write_i(wr),
    .branch_input_mode_i(m), .strobe_sel_i(sel), .branch_cond_pin3_i(pw),
    .ext_master_grant_o(g), .bus_drive_o(d), .xfer_hold_o(hold),
    .branch_cond_pin3_o(so), .branch_cond_pin3_oe_o(oe), .cond3_o(c3));
  dbarb_ext_master u_mst (.clock_i(clock_i), .want_i(want), .gnt_i(g), .req_o(req), .drv_o());
  always #10 clock_i = ~clock_i;
  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // Bounded wait so a missing grant cannot hang the run
  task automatic wait_g(input logic v);
    for (int i = 0; i < 20 && g !== v; i++) @(negedge clock_i);
  endtask
  task automatic t_grant;
    want <= 1'h1;
    wait_g(1'h1);
    chk({1'h0, g, d, hold}, 4'h5);
    want <= 1'h0;
    cyc(5);
    chk({1'h0, g, d, hold}, 4'h2);
    $display("grant done");
  endtask
  task automatic t_xfer;
    x <= 1'h1;
    want <= 1'h1;
    cyc(6);
    chk({g, d}, 4'h1);
    x <= 1'h0;
    wait_g(1'h1);
    chk({g, d}, 4'h2);
    want <= 1'h0;
    cyc(5);
    $display("xfer done");
  endtask
  task automatic t_reclaim;
    p <= 1'h1;
    w <= 1'h1;
    want <= 1'h1;
    wait_g(1'h1);
    wait_g(1'h0);
    chk({g, d}, 4'h0);
    cyc(5);
    chk({req, g, d}, 4'h1);
    {p, w, want} <= 3'h0;
    cyc(2);
    $display("reclaim done");
  endtask
  task automatic t_pin;
    pin <= 1'h1;
    cyc(2);
    chk({oe, c3}, 4'h1);
    m <= 1'h0;
    cyc(2);
    chk({oe, c3, so}, 4'h4);
    sel <= 2'h1;
    x <= 1'h1;
    cyc(1);
    chk(so, 4'h0);
    cyc(1);
    chk(so, 4'h1);
    cyc(2);
    chk(so, 4'h1);
    x <= 1'h0;
    wr <= 1'h1;
    cyc(2);
    x <= 1'h1;
    cyc(4);
    chk(so, 4'h0);
    x <= 1'h0;
    cyc(2);
    sel <= 2'h2;
    x <= 1'h1;
    cyc(1);
    chk(so, 4'h0);
    cyc(1);
    chk(so, 4'h1);
    x <= 1'h0;
    cyc(2);
    chk(so, 4'h0);
    $display("pin done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cycle ceiling well above the expected run
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 1000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    cyc(16);
    rst_b_i <= 1'h1;
    cyc(2);
    t_grant();
    t_xfer();
    t_reclaim();
    t_pin();
    summarize();
  end
endmodule
